// File: rtl/mif_debounce.v
// mouse input front end: one button debouncer channel
// assumes the raw button is synchronous to clk, low while pressed
`include "mif_map.vh"
module mif_debounce #(
	parameter COUNT = `MIF_DEBOUNCE_CYC,
	parameter CW = `MIF_DEB_CNT_W
) (
	input wire clk,
	input wire reset_n,
	input wire button_n,
	output reg pressed,
	output reg changed
);
	reg level;
	reg [CW-1:0] cnt;
	always @(posedge clk) begin
		if (!reset_n) begin
			level <= `MIF_BTN_IDLE;
			cnt <= {CW{1'b0}};
			pressed <= 1'b0;
			changed <= 1'b0;
		end else begin
			changed <= 1'b0;
			if (button_n == level) begin
				cnt <= {CW{1'b0}};
			end else if (cnt == COUNT[CW-1:0] - 1'b1) begin
				// stable for the whole interval: accept
				level <= button_n;
				pressed <= ~button_n;
				changed <= 1'b1;
				cnt <= {CW{1'b0}};
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end
endmodule // mif_debounce

// File: rtl/mif_front_end.v
// mouse input front end: wheel decoder, buttons and sensor poller
// assumes all pins synchronous to clk; sensor access by a simple
// request/done register read port outside this block
// the read port answers each read with a one-cycle done pulse
//
// How it works
// - every single change of the wheel quadrature pair counts one step
// - old versus new quadrature state gives direction; cw and ccw opposite
// - quadrature decoding is only for the wheel; x and y come from sensor
// - buttons idle high via pull-up; closed switch pulls to ground
// - low button level means pressed
// - high button level means released
// - each button must stay stable about 17 ms before change is accepted
// - three button channels: left, wheel press, right
// - periodically read low x, low y and shared high xy sensor registers
`include "mif_map.vh"
module mif_front_end #(
	parameter POLL_CYCLES = `MIF_POLL_CYC,
	parameter DEB_CYCLES = `MIF_DEBOUNCE_CYC,
	parameter WHEEL_W = 8
) (
	input wire clk,
	input wire reset_n,
	input wire wheel_a,
	input wire wheel_b,
	input wire left_button_n,
	input wire wheel_button_n,
	input wire right_button_n,
	output reg button_pull_up_en,
	output reg [2:0] buttons_pressed,
	output reg buttons_changed,
	output reg signed [WHEEL_W-1:0] wheel_count,
	output reg wheel_step,
	output reg wheel_dir_ccw,
	output reg sensor_rd_req,
	output reg [6:0] sensor_rd_addr,
	input wire sensor_rd_done,
	input wire [7:0] sensor_rd_data,
	output reg signed [11:0] motion_x,
	output reg signed [11:0] motion_y,
	output reg motion_valid
);
	// ************************************************
	// wheel quadrature decoder
	// ************************************************
	reg [1:0] quad_prev;
	wire [1:0] quad_now;
	wire [1:0] quad_diff;
	wire quad_single;
	wire quad_double;
	wire step_ccw;

	assign quad_now = {wheel_a, wheel_b};
	assign quad_diff = quad_now ^ quad_prev;
	// exactly one line moved: a legal step of the gray sequence
	assign quad_single = (quad_diff == `MIF_QUAD_B_MOVED) ||
		(quad_diff == `MIF_QUAD_A_MOVED);
	// both lines moved: a state was skipped, direction is unknown
	assign quad_double = (quad_diff == `MIF_QUAD_BOTH_MOVED);
	// gray order 00-01-11-10 is clockwise: there new b is old a inverted,
	// so old a equal to new b means a counter-clockwise step
	assign step_ccw = ~(quad_prev[1] ^ quad_now[0]);
	// the pair is sampled on every rising edge; a step shows one edge later
	always @(posedge clk) begin
		if (!reset_n) begin
			quad_prev <= `MIF_QUAD_IDLE;
			wheel_count <= {WHEEL_W{1'b0}};
			wheel_step <= 1'b0;
			wheel_dir_ccw <= 1'b0;
		end else begin
			wheel_step <= 1'b0;
			// only the wheel is decoded here
			quad_prev <= quad_now;
			if (quad_single) begin
				wheel_step <= 1'b1;
				wheel_dir_ccw <= step_ccw;
				if (step_ccw)
					wheel_count <= wheel_count - 1'b1;
				else
					wheel_count <= wheel_count + 1'b1;
			end else if (quad_double) begin
				// skipped state: resync only, count and direction kept
				wheel_step <= 1'b0;
			end
		end
	end

	// ************************************************
	// buttons
	// ************************************************
	wire [`MIF_BTN_COUNT-1:0] raw_n;
	wire [`MIF_BTN_COUNT-1:0] deb_pressed;
	wire [`MIF_BTN_COUNT-1:0] deb_changed;
	genvar i;
	assign raw_n[`MIF_BTN_LEFT] = left_button_n;
	assign raw_n[`MIF_BTN_WHEEL] = wheel_button_n;
	assign raw_n[`MIF_BTN_RIGHT] = right_button_n;
	// one debouncer per switch; the channels never wait on each other
	generate
		for (i = 0; i < `MIF_BTN_COUNT; i = i + 1) begin : g_btn
			mif_debounce #(
				.COUNT(DEB_CYCLES),
				.CW(`MIF_DEB_CNT_W)
			) u_deb (
				.clk(clk),
				.reset_n(reset_n),
				.button_n(raw_n[i]),
				.pressed(deb_pressed[i]),
				.changed(deb_changed[i])
			);
		end
	endgenerate
	always @(posedge clk) begin
		if (!reset_n) begin
			button_pull_up_en <= 1'b0;
			buttons_pressed <= 3'h0;
			buttons_changed <= 1'b0;
		end else begin
			// pull-ups stay enabled so an open switch reads high
			button_pull_up_en <= 1'b1;
			// one register stage so every output comes from a flip-flop
			buttons_pressed <= deb_pressed;
			buttons_changed <= |deb_changed;
		end
	end

	// ************************************************
	// sensor poller
	// ************************************************
	// one-hot states: idle, then one per read of the burst
	localparam S_IDLE = 4'h1;
	localparam S_RDX = 4'h2;
	localparam S_RDY = 4'h4;
	localparam S_RDH = 4'h8;
	reg [3:0] state;
	reg [`MIF_POLL_CNT_W-1:0] poll_cnt;
	reg [7:0] dx_low;
	reg [7:0] dy_low;
	wire poll_due;
	reg [6:0] next_addr;
	wire [7:0] motion_xy_high_nibbles;
	wire signed [11:0] burst_x;
	wire signed [11:0] burst_y;

	// the timer runs only while idle: the period is counted from the end
	// of one burst, so a slow sensor never sees two bursts overlap
	assign poll_due = (poll_cnt ==
		POLL_CYCLES[`MIF_POLL_CNT_W-1:0] - 1'b1);
	always @(posedge clk) begin
		if (!reset_n) begin
			poll_cnt <= {`MIF_POLL_CNT_W{1'b0}};
		end else if (state != S_IDLE || poll_due) begin
			poll_cnt <= {`MIF_POLL_CNT_W{1'b0}};
		end else begin
			poll_cnt <= poll_cnt + 1'b1;
		end
	end

	// address of the read that follows; the fixed order keeps the low
	// bytes and the shared high byte of one burst together
	always @* begin
		case (state)
		S_IDLE: next_addr = `MIF_REG_DX_LOW;
		S_RDX: next_addr = `MIF_REG_DY_LOW;
		S_RDY: next_addr = `MIF_REG_XY_HIGH;
		default: next_addr = sensor_rd_addr;
		endcase
	end

	// the shared high byte holds the top nibble of both axes
	assign motion_xy_high_nibbles = sensor_rd_data;
	assign burst_x = {motion_xy_high_nibbles[`MIF_HI_X_MSB:`MIF_HI_X_LSB],
		dx_low};
	assign burst_y = {motion_xy_high_nibbles[`MIF_HI_Y_MSB:`MIF_HI_Y_LSB],
		dy_low};
	always @(posedge clk) begin
		if (!reset_n) begin
			state <= S_IDLE;
			sensor_rd_req <= 1'b0;
			sensor_rd_addr <= 7'h00;
			dx_low <= 8'h00;
			dy_low <= 8'h00;
			motion_x <= 12'h000;
			motion_y <= 12'h000;
			motion_valid <= 1'b0;
		end else begin
			motion_valid <= 1'b0;
			case (state)
			S_IDLE: begin
				// a done pulse outside a burst is never looked at
				if (poll_due) begin
					sensor_rd_req <= 1'b1;
					sensor_rd_addr <= next_addr;
					state <= S_RDX;
				end
			end
			S_RDX: begin
				if (sensor_rd_done) begin
					dx_low <= sensor_rd_data;
					sensor_rd_addr <= next_addr;
					state <= S_RDY;
				end
			end
			S_RDY: begin
				if (sensor_rd_done) begin
					dy_low <= sensor_rd_data;
					sensor_rd_addr <= next_addr;
					state <= S_RDH;
				end
			end
			S_RDH: begin
				if (sensor_rd_done) begin
					// high nibbles: x in [7:4], y in [3:0]
					motion_x <= burst_x;
					motion_y <= burst_y;
					motion_valid <= 1'b1;
					sensor_rd_req <= 1'b0;
					state <= S_IDLE;
				end
			end
			default: begin
				sensor_rd_req <= 1'b0;
				state <= S_IDLE;
			end
			endcase
		end
	end
endmodule // mif_front_end

// File: rtl/mif_map.vh
// mouse input front end: shared constants
// assumes a 100 MHz clock; included by the design files by bare name
`ifndef MIF_MAP_VH
`define MIF_MAP_VH
// debounce interval in microseconds (recommended 15-20 ms window)
`define MIF_DEBOUNCE_US 17000
`define MIF_CLK_MHZ 100
`define MIF_DEBOUNCE_CYC (`MIF_DEBOUNCE_US * `MIF_CLK_MHZ)
// poll period of the optical sensor in microseconds
`define MIF_POLL_US 1000
`define MIF_POLL_CYC (`MIF_POLL_US * `MIF_CLK_MHZ)
// sensor register indices
`define MIF_REG_DX_LOW 7'h03
`define MIF_REG_DY_LOW 7'h04
`define MIF_REG_XY_HIGH 7'h05
// button reset level: released (switch open, pulled high)
`define MIF_BTN_IDLE 1'b1
`define MIF_QUAD_IDLE 2'h0
// counter widths: must hold the default debounce and poll counts
`define MIF_DEB_CNT_W 21
`define MIF_POLL_CNT_W 24
// quadrature difference codes: which lines moved since the last sample
`define MIF_QUAD_B_MOVED 2'h1
`define MIF_QUAD_A_MOVED 2'h2
`define MIF_QUAD_BOTH_MOVED 2'h3
// button channels and their bit positions
`define MIF_BTN_COUNT 3
`define MIF_BTN_LEFT 0
`define MIF_BTN_WHEEL 1
`define MIF_BTN_RIGHT 2
// shared high byte: x nibble on top, y nibble below
`define MIF_HI_X_MSB 7
`define MIF_HI_X_LSB 4
`define MIF_HI_Y_MSB 3
`define MIF_HI_Y_LSB 0
`endif

// File: testbench/mif_front_end_assertions.sv
// checker bound to mif_front_end, sees its ports only
// assumes one clock and the synchronous active-low reset_n
module mif_chk #(parameter WHEEL_W = 8, DEB_CYCLES = 8) (
	input wire clk, reset_n, wheel_a, wheel_b, left_button_n,
	input wire button_pull_up_en, buttons_changed, wheel_step,
	input wire wheel_dir_ccw, sensor_rd_req, sensor_rd_done, motion_valid,
	input wire [2:0] buttons_pressed,
	input wire [6:0] sensor_rd_addr,
	input wire signed [WHEEL_W-1:0] wheel_count
);
	timeunit 1ns; timeprecision 1ns;
	wire [1:0] q = {wheel_a, wheel_b};
	reg [1:0] up;
	reg [20:0] lc;
	// up masks the first edges, while quad_prev still holds its reset 00
	always @(posedge clk) begin
		up <= reset_n ? {up[0], 1'b1} : 2'h0;
		lc <= left_button_n ? 21'h0 : lc + 21'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_rd(a);
		sensor_rd_req && sensor_rd_done && sensor_rd_addr == a;
	endsequence
	a_step_single:
	assert property (up[1] |-> wheel_step ==
		($countones($past(q) ^ $past(q, 2)) == 1)) else $error("step");
	a_dir_sense:
	assert property (wheel_step && $past(q, 2) == 2'h0 |->
		wheel_dir_ccw == ($past(q) == 2'h2)) else $error("dir");
	a_count_step:
	assert property (wheel_step |-> WHEEL_W'(wheel_count - $past(wheel_count))
		== WHEEL_W'(wheel_dir_ccw ? -1 : 1)) else $error("count");
	a_count_hold:
	assert property (!wheel_step |-> $stable(wheel_count)) else $error("hold");
	a_pull_up_on:
	assert property (up[1] |-> button_pull_up_en) else $error("pull up");
	a_btn_change:
	assert property (up[1] |-> buttons_changed ==
		(buttons_pressed != $past(buttons_pressed))) else $error("changed");
	a_btn_debounce:
	assert property ($rose(buttons_pressed[0]) |-> lc == DEB_CYCLES + 1)
		else $error("debounce");
	a_poll_next:
	assert property (s_rd(7'h03) |=> sensor_rd_req && sensor_rd_addr == 7'h04)
		else $error("poll order");
	a_poll_end:
	assert property (s_rd(7'h05) |=> !sensor_rd_req && motion_valid)
		else $error("poll end");
endmodule // mif_chk
bind mif_front_end mif_chk #(.WHEEL_W(WHEEL_W), .DEB_CYCLES(DEB_CYCLES))
	u_chk (.*);

// File: testbench/mif_sensor.sv
// optical sensor model answering each read of a poll burst
// shares the block clock; dly cycles pass before each answer
module mif_sensor (
	input wire clk,
	input wire sensor_rd_req,
	input wire [6:0] sensor_rd_addr,
	input wire [3:0] dly,
	input wire [7:0] dx, dy, hxy,
	output logic sensor_rd_done = 1'b0,
	output logic [7:0] sensor_rd_data = 8'h00
);
	timeunit 1ns; timeprecision 1ns;
	logic [3:0] n;
	always @(posedge clk) begin
		sensor_rd_done <= 1'b0;
		// no stale data once the answer cycle has passed
		if (sensor_rd_done)
			sensor_rd_data <= ~sensor_rd_data;
		if (!sensor_rd_req)
			n <= 4'h0;
		else if (!sensor_rd_done && n == dly) begin
			n <= 4'h0;
			sensor_rd_done <= 1'b1;
			sensor_rd_data <= sensor_rd_addr == 7'h03 ? dx :
				sensor_rd_addr == 7'h04 ? dy : hxy;
		end else if (!sensor_rd_done)
			n <= n + 4'h1;
	end
endmodule // mif_sensor

// File: testbench/testbench.sv
// testbench: pins change at the falling edge, sensor model answers
// assumes the nets here carry the DUT port names, joined by name
module testbench;
	timeunit 1ns; timeprecision 1ns;
	logic clk = 1'b0, reset_n = 1'b0, wheel_a = 1'b0, wheel_b = 1'b0;
	logic left_button_n = 1'b1, wheel_button_n = 1'b1, right_button_n = 1'b1;
	logic [3:0] dly = 4'h0;
	logic [7:0] dx = 8'h00, dy = 8'h00, hxy = 8'h00, sensor_rd_data;
	logic button_pull_up_en, buttons_changed, wheel_step, wheel_dir_ccw;
	logic sensor_rd_req, sensor_rd_done, motion_valid;
	logic [2:0] buttons_pressed;
	logic [6:0] sensor_rd_addr;
	logic signed [7:0] wheel_count;
	logic signed [11:0] motion_x, motion_y;
	int errors = 0, n_tests = 0, cyc = 0;
	byte ec[8] = '{1, 2, 3, 4, 3, 2, 2, 3};
	mif_front_end #(.POLL_CYCLES(20), .DEB_CYCLES(8)) DUT (.*);
	mif_sensor u_sensor (.*);
	initial forever #5 clk = ~clk;
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string s, input logic [11:0] e, g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task t_wheel;
		// cw four, ccw two, a double change, then one cw from 00
		for (int i = 0; i < 8; i++) begin
			{wheel_a, wheel_b} = 2'(16'h4E2D >> 2 * i);
			repeat (3) @(negedge clk);
			chk("count", 12'(ec[i]), 12'(wheel_count));
			chk("ccw", 12'(8'h70 >> i & 1), 12'(wheel_dir_ccw));
		end
		$display("wheel test done");
	endtask
	task t_button;
		for (int i = 0; i < 4; i++) begin
			{right_button_n, wheel_button_n, left_button_n} = ~(3'h1 << i % 3);
			repeat (i ? 12 : 5) @(negedge clk);
			chk("pressed", 12'(i ? 3'h1 << i % 3 : 3'h0),
				12'(buttons_pressed));
			{right_button_n, wheel_button_n, left_button_n} = 3'h7;
			repeat (12) @(negedge clk);
			chk("released", 12'h0, 12'(buttons_pressed));
		end
		chk("pull up", 12'h1, 12'(button_pull_up_en));
		$display("button test done");
	endtask
	task wait_mv;
		@(negedge clk);
		for (int k = 0; k < 200 && motion_valid !== 1'b1; k++)
			@(negedge clk);
	endtask
	task t_sense(input logic [7:0] x, y, h, input logic [3:0] d);
		wait_mv();
		{dx, dy, hxy, dly} = {x, y, h, d};
		wait_mv();
		chk("motion_x", {h[7:4], x}, motion_x);
		chk("motion_y", {h[3:0], y}, motion_y);
		$display("sensor test done");
	endtask
	initial begin
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		t_wheel();
		t_button();
		t_sense(8'hA5, 8'h3C, 8'h9E, 4'h0);
		t_sense(8'h5A, 8'hC3, 8'h61, 4'h9);
		report_and_stop();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			report_and_stop();
		end
	end
endmodule // testbench
